//--- src/hrcp_pkg.sv
// host read cycle port: shared constants
// assumes word index taken from address bits 6:2
package hrcp_pkg;
  localparam int unsigned HRCP_ADDR_W = 7;
  localparam int unsigned HRCP_DATA_W = 32;
  localparam int unsigned HRCP_HALF_W = 16;
  localparam int unsigned HRCP_IDX_LSB = 2;
  localparam int unsigned HRCP_IDX_MSB = 6;
  localparam int unsigned HRCP_HALF_BIT = 0;
  localparam logic [4:0] HRCP_IDX_RX_DATA = 5'h00;
  localparam logic [4:0] HRCP_IDX_RX_STS = 5'h08;
  localparam logic [4:0] HRCP_IDX_TX_STS = 5'h09;
  localparam logic [4:0] HRCP_BURST_MAX32 = 5'h08;
  localparam logic [4:0] HRCP_BURST_MAX16 = 5'h10;
  localparam logic [4:0] HRCP_CNT_ZERO = 5'h00;
  localparam logic [4:0] HRCP_CNT_ONE = 5'h01;
  localparam logic [1:0] HRCP_BUF_DEPTH = 2'h2;
  localparam logic [1:0] HRCP_BUF_ONE = 2'h1;
  localparam logic [31:0] HRCP_DATA_RST = 32'h0000_0000;
  localparam logic [15:0] HRCP_HALF_ZERO = 16'h0000;
  typedef enum logic [1:0] {
    HRCP_ST_IDLE = 2'b01,
    HRCP_ST_READ = 2'b10
  } hrcp_state_t;
endpackage : hrcp_pkg

//--- src/hrcp_host_read_cycle_port.sv
// host read cycle port: strobe decode, beat tracking, rx data buffer, read data out
// assumes pins already synchronous to clk_sys; csr block decodes the same address pins
`timescale 1ns/10ps
module hrcp_host_read_cycle_port (
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic chip_select_n,
  input wire logic read_strobe_n,
  input wire logic [6:0] addr,
  input wire logic fifo_sel,
  input wire logic bus16,
  output logic [31:0] data_o,
  output logic data_oe_lo,
  output logic data_oe_hi,
  input wire logic [31:0] csr_rd_data,
  input wire logic [31:0] rx_sts_data,
  output logic rx_sts_pop,
  input wire logic [31:0] tx_sts_data,
  output logic tx_sts_pop,
  input wire logic rx_data_valid,
  input wire logic [31:0] rx_data,
  output logic rx_data_ready
);
  hrcp_pkg::hrcp_state_t state_q;
  logic active;
  logic beat;
  logic take;
  logic limit_hit;
  logic half_hi;
  logic last_part;
  logic [4:0] idx;
  logic [4:0] limit;
  logic [4:0] cnt_q;
  logic [6:0] addr_q;
  logic sel_q;
  logic [31:0] data_q;
  logic sel_rx;
  logic sel_rxs;
  logic sel_txs;
  logic rx_pop;
  logic [31:0] buf_mem_q [2];
  logic wr_ptr_q;
  logic rd_ptr_q;
  logic [1:0] fill_q;
  logic buf_valid;
  logic push;
  logic [31:0] head;
  logic [31:0] word_sel;

  assign active = ~chip_select_n & ~read_strobe_n;
  // address or select change under held strobes starts a new beat
  assign beat = active & ((state_q == hrcp_pkg::HRCP_ST_IDLE) | (addr != addr_q)
    | (fifo_sel != sel_q));
  assign limit = bus16 ? hrcp_pkg::HRCP_BURST_MAX16 : hrcp_pkg::HRCP_BURST_MAX32;
  assign limit_hit = ~fifo_sel & (cnt_q >= limit);
  assign take = beat & ~limit_hit;
  assign idx = addr[hrcp_pkg::HRCP_IDX_MSB:hrcp_pkg::HRCP_IDX_LSB];
  assign half_hi = addr[hrcp_pkg::HRCP_HALF_BIT];
  assign last_part = ~bus16 | half_hi;
  assign sel_rx = fifo_sel | (idx == hrcp_pkg::HRCP_IDX_RX_DATA);
  assign sel_rxs = ~fifo_sel & (idx == hrcp_pkg::HRCP_IDX_RX_STS);
  assign sel_txs = ~fifo_sel & (idx == hrcp_pkg::HRCP_IDX_TX_STS);
  // fifos advance only on the last half of a word, so a 16-bit pair reads one entry
  assign rx_pop = take & sel_rx & buf_valid & last_part;
  assign rx_sts_pop = take & sel_rxs & last_part;
  assign tx_sts_pop = take & sel_txs & last_part;

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      state_q <= hrcp_pkg::HRCP_ST_IDLE;
    end else begin
      state_q <= active ? hrcp_pkg::HRCP_ST_READ : hrcp_pkg::HRCP_ST_IDLE;
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      addr_q <= '0;
      sel_q <= 1'b0;
    end else begin
      addr_q <= addr;
      sel_q <= fifo_sel;
    end
  end

  // counter saturates so a long direct burst cannot wrap it
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      cnt_q <= hrcp_pkg::HRCP_CNT_ZERO;
    end else if (!active) begin
      cnt_q <= hrcp_pkg::HRCP_CNT_ZERO;
    end else if (beat && !limit_hit && cnt_q != hrcp_pkg::HRCP_BURST_MAX16) begin
      cnt_q <= cnt_q + hrcp_pkg::HRCP_CNT_ONE;
    end
  end

  // two-entry buffer on the rx data path
  assign buf_valid = (fill_q != 2'h0);
  assign rx_data_ready = (fill_q != hrcp_pkg::HRCP_BUF_DEPTH);
  assign push = rx_data_valid & rx_data_ready;
  assign head = buf_mem_q[rd_ptr_q];

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      buf_mem_q[0] <= hrcp_pkg::HRCP_DATA_RST;
      buf_mem_q[1] <= hrcp_pkg::HRCP_DATA_RST;
      wr_ptr_q <= 1'b0;
    end else if (push) begin
      buf_mem_q[wr_ptr_q] <= rx_data;
      wr_ptr_q <= ~wr_ptr_q;
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      rd_ptr_q <= 1'b0;
      fill_q <= 2'h0;
    end else begin
      if (rx_pop) begin
        rd_ptr_q <= ~rd_ptr_q;
      end
      if (push && !rx_pop) begin
        fill_q <= fill_q + hrcp_pkg::HRCP_BUF_ONE;
      end else if (rx_pop && !push) begin
        fill_q <= fill_q - hrcp_pkg::HRCP_BUF_ONE;
      end
    end
  end

  always_comb begin
    word_sel = csr_rd_data;
    if (sel_rx) begin
      word_sel = buf_valid ? head : hrcp_pkg::HRCP_DATA_RST;
    end else if (sel_rxs) begin
      word_sel = rx_sts_data;
    end else if (sel_txs) begin
      word_sel = tx_sts_data;
    end
    if (bus16) begin
      word_sel = {hrcp_pkg::HRCP_HALF_ZERO,
        half_hi ? word_sel[hrcp_pkg::HRCP_DATA_W-1:hrcp_pkg::HRCP_HALF_W]
        : word_sel[hrcp_pkg::HRCP_HALF_W-1:0]};
    end
  end

  // captured once per beat: counters stay stable through the cycle
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      data_q <= hrcp_pkg::HRCP_DATA_RST;
    end else if (take) begin
      data_q <= word_sel;
    end
  end

  assign data_o = data_q;
  assign data_oe_lo = active & (state_q == hrcp_pkg::HRCP_ST_READ);
  assign data_oe_hi = data_oe_lo & ~bus16;

  sequence s_beat_csr;
    take & ~sel_rx & ~sel_rxs & ~sel_txs & ~bus16;
  endsequence
  sequence s_beat_direct;
    take & fifo_sel & ~bus16;
  endsequence

  property p_oe_window;
    @(posedge clk_sys) disable iff (!arst_n)
      data_oe_lo |-> (active && $past(active));
  endproperty
  a_oe_window: assert property (p_oe_window) else $error("oe outside read");

  property p_oe_off;
    @(posedge clk_sys) disable iff (!arst_n)
      !active |-> !data_oe_lo && !data_oe_hi;
  endproperty
  a_oe_off: assert property (p_oe_off) else $error("oe while idle");

  property p_hi_undriven;
    @(posedge clk_sys) disable iff (!arst_n)
      bus16 |-> !data_oe_hi;
  endproperty
  a_hi_undriven: assert property (p_hi_undriven) else $error("upper lanes driven");

  property p_csr_capture;
    @(posedge clk_sys) disable iff (!arst_n)
      s_beat_csr ##1 (active && !take)[*2] |-> data_o == $past(csr_rd_data, 2);
  endproperty
  a_csr_capture: assert property (p_csr_capture) else $error("csr value moved");

  property p_burst_cap;
    @(posedge clk_sys) disable iff (!arst_n)
      (!fifo_sel && !bus16 && cnt_q == hrcp_pkg::HRCP_BURST_MAX32) |-> !take;
  endproperty
  a_burst_cap: assert property (p_burst_cap) else $error("beat past burst limit");

  property p_direct_unlimited;
    @(posedge clk_sys) disable iff (!arst_n)
      (beat && fifo_sel && buf_valid && !bus16) |-> rx_pop;
  endproperty
  a_direct_unlimited: assert property (p_direct_unlimited) else $error("direct beat lost");

  property p_direct_data;
    @(posedge clk_sys) disable iff (!arst_n)
      (s_beat_direct and buf_valid) |=> data_o == $past(head);
  endproperty
  a_direct_data: assert property (p_direct_data) else $error("direct not from rx fifo");

  property p_direct_no_sts;
    @(posedge clk_sys) disable iff (!arst_n)
      fifo_sel |-> !rx_sts_pop && !tx_sts_pop;
  endproperty
  a_direct_no_sts: assert property (p_direct_no_sts) else $error("status popped in direct");

  property p_half_decode;
    @(posedge clk_sys) disable iff (!arst_n)
      (take && fifo_sel && bus16 && !addr[0]) |-> !rx_pop;
  endproperty
  a_half_decode: assert property (p_half_decode) else $error("low half popped");

  property p_sts_single;
    @(posedge clk_sys) disable iff (!arst_n)
      (take && sel_rxs && !bus16) |-> rx_sts_pop ##1 !rx_sts_pop || take;
  endproperty
  a_sts_single: assert property (p_sts_single) else $error("status read missed");
endmodule : hrcp_host_read_cycle_port

//--- tb/hrcp_far_model.sv
// far side model: rx data stream source and heads of both status fifos
// assumes clk_sys domain and one-cycle pop pulses from the port
`timescale 1ns/10ps
module hrcp_far_model (
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic stall,
  input wire logic rx_data_ready,
  output logic rx_data_valid,
  output logic [31:0] rx_data,
  input wire logic rx_sts_pop,
  output logic [31:0] rx_sts_data,
  input wire logic tx_sts_pop,
  output logic [31:0] tx_sts_data
);
  logic [31:0] n_q;
  logic [31:0] rs_q;
  logic [31:0] ts_q;
  logic hold_q;
  // an offered word stays up until taken, so a stall never withdraws it
  assign rx_data_valid = !stall || hold_q;
  // no stale word on the lines while nothing is offered
  assign rx_data = rx_data_valid ? 32'ha000_0000 + n_q : ~(32'ha000_0000 + n_q);
  assign rx_sts_data = 32'hb000_0000 + rs_q;
  assign tx_sts_data = 32'hd000_0000 + ts_q;
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      n_q <= 32'h0;
      rs_q <= 32'h0;
      ts_q <= 32'h0;
      hold_q <= 1'b0;
    end else begin
      hold_q <= rx_data_valid && !rx_data_ready;
      if (rx_data_valid && rx_data_ready) n_q <= n_q + 32'h1;
      if (rx_sts_pop) rs_q <= rs_q + 32'h1;
      if (tx_sts_pop) ts_q <= ts_q + 32'h1;
    end
  end
endmodule : hrcp_far_model

//--- tb/hrcp_host_read_cycle_port_tb.sv
// testbench: host reads of csr, fifos, bursts, direct mode, 16-bit, stall
// assumes far side model and host pins driven 1 ns after each rising edge
`timescale 1ns/10ps
module hrcp_host_read_cycle_port_tb;
  logic clk_sys, arst_n, chip_select_n, read_strobe_n, fifo_sel, bus16, stall;
  logic [6:0] addr;
  logic [31:0] data_o, csr_rd_data, rx_sts_data, tx_sts_data, rx_data, e;
  logic data_oe_lo, data_oe_hi, rx_sts_pop, tx_sts_pop, rx_data_valid, rx_data_ready;
  int n_fail, cmp_count, rx_k, rs_k, ts_k;
  // {source, fifo select, address}: 0 csr, 1 rx data, 2 rx status, 3 tx status
  logic [9:0] rows [7] = '{10'h004, 10'h100, 10'h220, 10'h324, 10'h1a0, 10'h1ff, 10'h220};
  assign csr_rd_data = {16'hc5c5, 9'h000, addr};
  hrcp_host_read_cycle_port i_dut (.clk_sys(clk_sys), .arst_n(arst_n),
    .chip_select_n(chip_select_n), .read_strobe_n(read_strobe_n), .addr(addr),
    .fifo_sel(fifo_sel), .bus16(bus16), .data_o(data_o), .data_oe_lo(data_oe_lo),
    .data_oe_hi(data_oe_hi), .csr_rd_data(csr_rd_data), .rx_sts_data(rx_sts_data),
    .rx_sts_pop(rx_sts_pop), .tx_sts_data(tx_sts_data), .tx_sts_pop(tx_sts_pop),
    .rx_data_valid(rx_data_valid), .rx_data(rx_data), .rx_data_ready(rx_data_ready));
  hrcp_far_model i_far (.clk_sys(clk_sys), .arst_n(arst_n), .stall(stall),
    .rx_data_ready(rx_data_ready), .rx_data_valid(rx_data_valid), .rx_data(rx_data),
    .rx_sts_pop(rx_sts_pop), .rx_sts_data(rx_sts_data), .tx_sts_pop(tx_sts_pop),
    .tx_sts_data(tx_sts_data));
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  task automatic finish_test;
    $display("compares %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : finish_test
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic step;
    @(posedge clk_sys);
    #1;
  endtask : step
  // beat taken and data captured at the next edge, strobes held one edge longer
  task automatic beat(input logic [6:0] a, input logic f);
    addr = a;
    fifo_sel = f;
    chip_select_n = 1'b0;
    read_strobe_n = 1'b0;
    step();
    step();
  endtask : beat
  // two cycles high covers the minimum deassertion time
  task automatic idle(input logic c);
    if (c) chip_select_n = 1'b1;
    else read_strobe_n = 1'b1;
    step();
    step();
  endtask : idle
  function automatic logic [31:0] ev(input logic [1:0] s, input logic [6:0] a);
    logic [31:0] v;
    case (s)
      2'd0: v = {16'hc5c5, 9'h000, a};
      2'd1: v = 32'ha000_0000 + rx_k;
      2'd2: v = 32'hb000_0000 + rs_k;
      default: v = 32'hd000_0000 + ts_k;
    endcase
    rx_k += (s == 2'd1);
    rs_k += (s == 2'd2);
    ts_k += (s == 2'd3);
    return v;
  endfunction : ev
  initial begin
    #20us;
    n_fail++;
    finish_test();
  end
  initial begin
    {arst_n, fifo_sel, bus16, stall, addr} = '0;
    {chip_select_n, read_strobe_n} = 2'b11;
    repeat (8) @(posedge clk_sys);
    #1;
    chk(data_o, 32'h0);
    chk({30'h0, data_oe_hi, data_oe_lo, rx_data_ready}, 32'h1);
    arst_n = 1'b1;
    step();
    $display("reset test done");
    foreach (rows[i]) begin
      beat(rows[i][6:0], rows[i][7]);
      e = ev(rows[i][9:8], rows[i][6:0]);
      chk(data_o, e);
      chk({30'h0, data_oe_hi, data_oe_lo}, 32'h3);
      idle(i[0]);
      chk({31'h0, data_oe_lo}, 32'h0);
      chk(data_o, e);
    end
    $display("single read test done");
    for (int i = 0; i < 10; i++) begin
      beat({i[4:0] + 5'h10, 2'b00}, 1'b0);
      if (i < 8) e = {16'hc5c5, 9'h000, i[4:0] + 5'h10, 2'b00};
      chk(data_o, e);
    end
    idle(1'b1);
    for (int i = 0; i < 12; i++) begin
      beat(i[6:0], 1'b1);
      chk(data_o, ev(2'd1, 7'h00));
    end
    idle(1'b0);
    // 40 ns reads: four dummies cover the wait before the level read
    for (int i = 0; i < 5; i++) begin
      beat(7'h18 + i[6:0], 1'b0);
      chk(data_o, {16'hc5c5, 9'h000, 7'h18 + i[6:0]});
      idle(i[0]);
    end
    $display("burst test done");
    bus16 = 1'b1;
    e = 32'ha000_0000 + rx_k;
    beat(7'h00, 1'b0);
    chk(data_o, {16'h0000, e[15:0]});
    chk({30'h0, data_oe_hi, data_oe_lo}, 32'h1);
    beat(7'h01, 1'b0);
    chk(data_o, {16'h0000, e[31:16]});
    rx_k++;
    idle(1'b1);
    for (int i = 0; i < 18; i++) begin
      beat(7'h40 + i[6:0], 1'b0);
      if (i < 16) e = i[0] ? 32'h0000_c5c5 : {25'h0, 7'h40 + i[6:0]};
      chk(data_o, e);
    end
    idle(1'b0);
    bus16 = 1'b0;
    $display("half width test done");
    repeat (3) step();
    stall = 1'b1;
    // one offered word still lands after the two buffered ones
    for (int i = 0; i < 4; i++) begin
      beat(7'h00, 1'b0);
      chk(data_o, (i < 3) ? ev(2'd1, 7'h00) : 32'h0);
      idle(i[0]);
    end
    stall = 1'b0;
    repeat (3) step();
    beat(7'h00, 1'b0);
    chk(data_o, ev(2'd1, 7'h00));
    idle(1'b1);
    $display("stall test done");
    // reset with strobes already low: first read lands at the first edge after release
    addr = 7'h24;
    {chip_select_n, read_strobe_n} = 2'b00;
    arst_n = 1'b0;
    step();
    chk(data_o, 32'h0);
    chk({30'h0, data_oe_hi, data_oe_lo, rx_data_ready}, 32'h1);
    ts_k = 0;
    arst_n = 1'b1;
    step();
    step();
    chk(data_o, ev(2'd3, 7'h24));
    chk({30'h0, data_oe_hi, data_oe_lo}, 32'h3);
    idle(1'b1);
    $display("mid-run reset test done");
    finish_test();
  end
endmodule : hrcp_host_read_cycle_port_tb
